// [hw/cfg_msg_pkg.sv]
// Shared types and constants for the configuration message interpreter.
// Assumes a byte-wide token stream with a control flag per token.
package cfg_msg_pkg;
  localparam logic [7:0] TOK_WRITE = 8'h_C0;
  localparam logic [7:0] TOK_READ = 8'h_C1;
  localparam logic [7:0] TOK_END = 8'h_01;
  localparam logic [7:0] TOK_ACK = 8'h_03;
  localparam logic [7:0] TOK_NACK = 8'h_04;
  localparam logic [7:0] NO_REPLY_BYTE = 8'h_FF;
  localparam logic [15:0] DEST_TILE = 16'h_C20C;
  localparam logic [15:0] DEST_NODE = 16'h_C30C;
  localparam logic [2:0] RESP_BYTES = 3'h_3;
  localparam logic [2:0] REGN_BYTES = 3'h_2;
  localparam logic [2:0] DATA_BYTES = 3'h_4;
  localparam logic [2:0] RD_REPLY_LAST = 3'h_5;
  localparam logic [2:0] SHORT_REPLY_LAST = 3'h_1;
  localparam int FIFO_DEPTH = 16;

  typedef enum logic [1:0] {
    BANK_NONE = 2'h_0,
    BANK_TILE = 2'h_1,
    BANK_NODE = 2'h_2
  } bank_t;

  typedef struct packed {
    logic ctrl;
    logic [7:0] data;
  } tok_t;

  typedef struct packed {
    bank_t bank;
    tok_t tok;
  } in_word_t;
endpackage

// [hw/cfg_msg_access.sv]
// Message-driven access to tile and node configuration registers.
// Assumes the token stream and the register banks run on mclk.
//
// What this block does
// - Low reply byte all ones suppresses write reply
// - Multi-byte fields travel most significant first
// - Destination low half C20C selects tile bank
// - Destination low half C30C selects node bank
// - Write reply: 3,1 success; 4,1 failure
// - Read reply: 3, data, 1; or 4,1

module sync_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic [AW:0] count_next;
  logic push;
  logic pop;

  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_valid = count_reg != '0;
  assign out_data = mem[rd_ptr_reg];

  always_comb begin
    count_next = count_reg;
    if (push && !pop) begin
      count_next = count_reg + 1'b1;
    end else if (pop && !push) begin
      count_next = count_reg - 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
      in_ready <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      count_reg <= count_next;
      // Registered ready; a full FIFO refuses until a word drains
      in_ready <= count_next != (AW + 1)'(DEPTH);
    end
  end
endmodule

module cfg_msg_access (
  input wire logic mclk,
  input wire logic srst,
  input wire cfg_msg_pkg::tok_t rx_tok,
  input wire logic [31:0] rx_dest,
  input wire logic rx_valid,
  output logic rx_ready,
  output cfg_msg_pkg::tok_t tx_tok,
  output logic [23:0] tx_dest,
  output logic tx_valid,
  input wire logic tx_ready,
  output logic acc_req,
  output logic acc_write,
  output logic acc_node,
  output logic [15:0] acc_reg,
  output logic [31:0] acc_wdata,
  input wire logic acc_done,
  input wire logic acc_ok,
  input wire logic [31:0] acc_rdata
);
  import cfg_msg_pkg::*;

  typedef enum logic [7:0] {
    ST_IDLE = 8'b0000_0001,
    ST_RESP = 8'b0000_0010,
    ST_REGN = 8'b0000_0100,
    ST_DATA = 8'b0000_1000,
    ST_END = 8'b0001_0000,
    ST_DRAIN = 8'b0010_0000,
    ST_ACC = 8'b0100_0000,
    ST_REPLY = 8'b1000_0000
  } state_t;

  function automatic bank_t decode_bank(input logic [31:0] dest);
    if (dest[15:0] == DEST_TILE) begin
      return BANK_TILE;
    end else if (dest[15:0] == DEST_NODE) begin
      return BANK_NODE;
    end
    return BANK_NONE;
  endfunction

  in_word_t in_word;
  in_word_t fifo_word;
  logic fifo_valid;
  logic take;
  state_t state_reg;
  logic [2:0] cnt_reg;
  logic is_write_reg;
  logic ok_reg;
  logic hdr_done_reg;
  bank_t bank_reg;
  logic [23:0] resp_reg;
  logic [31:0] rdata_reg;
  tok_t reply_tok;

  assign in_word = '{bank: decode_bank(rx_dest), tok: rx_tok};

  sync_fifo #(.WIDTH($bits(in_word_t)), .DEPTH(FIFO_DEPTH)) in_fifo (
    .mclk(mclk),
    .srst(srst),
    .in_data(in_word),
    .in_valid(rx_valid),
    .in_ready(rx_ready),
    .out_data(fifo_word),
    .out_valid(fifo_valid),
    .out_ready(take)
  );

  // Parser stalls the FIFO while an access or a reply is in flight
  assign take = fifo_valid && !(state_reg inside {ST_ACC, ST_REPLY});

  // Reply sequence, indexed by cnt_reg
  always_comb begin
    reply_tok = '{ctrl: 1'b1, data: TOK_END};
    if (cnt_reg == 3'h_0) begin
      reply_tok.data = ok_reg ? TOK_ACK : TOK_NACK;
    end else if (ok_reg && !is_write_reg && cnt_reg != RD_REPLY_LAST) begin
      reply_tok.ctrl = 1'b0;
      reply_tok.data = rdata_reg[31:24];
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      state_reg <= ST_IDLE;
      cnt_reg <= '0;
      is_write_reg <= 1'b0;
      ok_reg <= 1'b0;
      hdr_done_reg <= 1'b0;
      bank_reg <= BANK_NONE;
      resp_reg <= '0;
      acc_reg <= '0;
      acc_wdata <= '0;
      acc_req <= 1'b0;
      rdata_reg <= '0;
    end else begin
      acc_req <= 1'b0;
      unique case (state_reg)
        ST_IDLE: begin
          cnt_reg <= '0;
          hdr_done_reg <= 1'b0;
          ok_reg <= 1'b1;
          // Stray tokens between messages are dropped
          if (take && fifo_word.tok.ctrl &&
              (fifo_word.tok.data == TOK_WRITE || fifo_word.tok.data == TOK_READ)) begin
            is_write_reg <= fifo_word.tok.data == TOK_WRITE;
            bank_reg <= fifo_word.bank;
            state_reg <= ST_RESP;
          end
        end
        ST_RESP, ST_REGN, ST_DATA: begin
          if (take && fifo_word.tok.ctrl) begin
            ok_reg <= 1'b0;
            cnt_reg <= '0;
            state_reg <= fifo_word.tok.data == TOK_END ? ST_ACC : ST_DRAIN;
          end else if (take) begin
            cnt_reg <= cnt_reg + 1'b1;
            if (state_reg == ST_RESP) begin
              resp_reg <= {resp_reg[15:0], fifo_word.tok.data};
              if (cnt_reg == RESP_BYTES - 1'b1) begin
                hdr_done_reg <= 1'b1;
                cnt_reg <= '0;
                state_reg <= ST_REGN;
              end
            end else if (state_reg == ST_REGN) begin
              acc_reg <= {acc_reg[7:0], fifo_word.tok.data};
              if (cnt_reg == REGN_BYTES - 1'b1) begin
                cnt_reg <= '0;
                state_reg <= is_write_reg ? ST_DATA : ST_END;
              end
            end else begin
              acc_wdata <= {acc_wdata[23:0], fifo_word.tok.data};
              if (cnt_reg == DATA_BYTES - 1'b1) begin
                cnt_reg <= '0;
                state_reg <= ST_END;
              end
            end
          end
        end
        ST_END, ST_DRAIN: begin
          if (take && fifo_word.tok.ctrl && fifo_word.tok.data == TOK_END) begin
            cnt_reg <= '0;
            state_reg <= ST_ACC;
            if (ok_reg && state_reg == ST_END && bank_reg != BANK_NONE) begin
              acc_req <= 1'b1;
            end else begin
              ok_reg <= 1'b0;
            end
          end else if (take) begin
            ok_reg <= 1'b0;
            state_reg <= ST_DRAIN;
          end
        end
        ST_ACC: begin
          // Without acc_req the message already failed; go straight on
          if (acc_done || !ok_reg) begin
            if (ok_reg) begin
              ok_reg <= acc_ok;
              rdata_reg <= acc_rdata;
            end
            // A header cut short leaves no address to answer to
            if (!hdr_done_reg ||
                (is_write_reg && resp_reg[7:0] == NO_REPLY_BYTE)) begin
              state_reg <= ST_IDLE;
            end else begin
              state_reg <= ST_REPLY;
            end
          end
        end
        ST_REPLY: begin
          if (!tx_valid || tx_ready) begin
            if (tx_valid && tx_tok.ctrl && tx_tok.data == TOK_END) begin
              state_reg <= ST_IDLE;
            end else begin
              cnt_reg <= cnt_reg + 1'b1;
              if (cnt_reg != 3'h_0 && !reply_tok.ctrl) begin
                rdata_reg <= {rdata_reg[23:0], 8'h_00};
              end
            end
          end
        end
      endcase
    end
  end

  // Access qualifiers follow the captured header
  always_ff @(posedge mclk) begin
    if (srst) begin
      acc_write <= 1'b0;
      acc_node <= 1'b0;
    end else begin
      acc_write <= is_write_reg;
      acc_node <= bank_reg == BANK_NODE;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      tx_valid <= 1'b0;
      tx_tok <= '0;
      tx_dest <= '0;
    end else if (!tx_valid || tx_ready) begin
      tx_valid <= 1'b0;
      if (state_reg == ST_REPLY &&
          !(tx_valid && tx_tok.ctrl && tx_tok.data == TOK_END)) begin
        tx_valid <= 1'b1;
        tx_tok <= reply_tok;
        tx_dest <= resp_reg;
      end
    end
  end

  no_reply_a: assert property (@(posedge mclk) disable iff (srst)
    state_reg == ST_ACC && acc_done && ok_reg && is_write_reg && resp_reg[7:0] == NO_REPLY_BYTE
    |=> state_reg == ST_IDLE ##1 !tx_valid)
    else $error("write reply not suppressed");

  reply_head_a: assert property (@(posedge mclk) disable iff (srst)
    $rose(tx_valid) |-> tx_tok.ctrl && (tx_tok.data == TOK_ACK || tx_tok.data == TOK_NACK))
    else $error("reply does not open with 3 or 4");

  reply_tail_a: assert property (@(posedge mclk) disable iff (srst)
    tx_valid && tx_ready && tx_tok.ctrl && tx_tok.data == TOK_END |=> !tx_valid)
    else $error("tokens after closing token");

  read_data_a: assert property (@(posedge mclk) disable iff (srst)
    tx_valid && !tx_tok.ctrl |-> ok_reg && !is_write_reg)
    else $error("data byte in write or failed reply");

  fail_short_a: assert property (@(posedge mclk) disable iff (srst)
    tx_valid && tx_ready && tx_tok.ctrl && tx_tok.data == TOK_NACK
    |=> tx_valid && tx_tok.ctrl && tx_tok.data == TOK_END)
    else $error("failure reply not 4 then 1");

  tile_route_a: assert property (@(posedge mclk) disable iff (srst)
    acc_req |-> bank_reg != BANK_NONE ##1 acc_node == (bank_reg == BANK_NODE))
    else $error("access sent to wrong bank");

  regnum_msb_a: assert property (@(posedge mclk) disable iff (srst)
    state_reg == ST_REGN && take && !fifo_word.tok.ctrl
    |=> acc_reg == {$past(acc_reg[7:0]), $past(fifo_word.tok.data)})
    else $error("register number not shifted msb first");

  req_pulse_a: assert property (@(posedge mclk) disable iff (srst)
    acc_req |=> !acc_req && state_reg == ST_ACC)
    else $error("access request not a single pulse");

  reply_dest_a: assert property (@(posedge mclk) disable iff (srst)
    tx_valid |-> tx_dest == resp_reg)
    else $error("reply sent to wrong channel end");

  write_ok_c: cover property (@(posedge mclk) disable iff (srst)
    acc_req && acc_write ##[1:20] tx_valid && tx_tok.data == TOK_ACK);
  read_ok_c: cover property (@(posedge mclk) disable iff (srst)
    tx_valid && tx_ready && !tx_tok.ctrl);
  fail_c: cover property (@(posedge mclk) disable iff (srst)
    tx_valid && tx_tok.ctrl && tx_tok.data == TOK_NACK);
  suppress_c: cover property (@(posedge mclk) disable iff (srst)
    state_reg == ST_ACC && acc_done && is_write_reg && resp_reg[7:0] == NO_REPLY_BYTE);
endmodule

// [test/cfg_bank_model.sv]
// Register bank model standing behind the access port of the message interpreter.
// Assumes one access at a time, qualifiers settled from the cycle after acc_req.
module cfg_bank_model #(
  parameter int NREG = 16
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic acc_req,
  input wire logic acc_write,
  input wire logic acc_node,
  input wire logic [15:0] acc_reg,
  input wire logic [31:0] acc_wdata,
  output logic acc_done,
  output logic acc_ok,
  output logic [31:0] acc_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] mem [2][NREG];
  int cnt;
  always @(posedge mclk) begin
    acc_done <= 1'b0;
    acc_ok <= 1'b0;
    // Idle data keeps toggling so a stale sample never looks right
    acc_rdata <= ~acc_rdata;
    if (srst) begin
      cnt <= 0;
      acc_rdata <= 32'h_A5A5_A5A5;
      foreach (mem[b, r]) mem[b][r] <= 32'h_0000_0000;
    end else if (acc_req) begin
      cnt <= 1 + $urandom % 3;
    end else if (cnt == 1) begin
      cnt <= 0;
      acc_done <= 1'b1;
      acc_ok <= (acc_reg < NREG);
      if (acc_reg < NREG && acc_write) mem[acc_node][acc_reg] <= acc_wdata;
      if (acc_reg < NREG) acc_rdata <= mem[acc_node][acc_reg];
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end
  end
endmodule

// [test/config_register_message_access_test.sv]
// Self-checking bench: requester tasks feed messages, replies checked on arrival.
// Assumes the bank model answers the access port; reply stalls fill the input FIFO.
module config_register_message_access_test;
  timeunit 1ns;
  timeprecision 1ps;
  import cfg_msg_pkg::*;
  localparam int NREG = 16;
  logic mclk, srst, rx_valid, rx_ready, tx_valid, tx_ready;
  tok_t rx_tok, tx_tok;
  logic [31:0] rx_dest, acc_wdata, acc_rdata;
  logic [23:0] tx_dest;
  logic acc_req, acc_write, acc_node, acc_done, acc_ok;
  logic [15:0] acc_reg;
  logic [31:0] shadow [2][NREG];
  logic [32:0] exp_q [$];
  int error_cnt = 0, cmp_count = 0, refused = 0, cyc = 0;
  cfg_msg_access dut (.mclk(mclk), .srst(srst), .rx_tok(rx_tok), .rx_dest(rx_dest),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .tx_tok(tx_tok), .tx_dest(tx_dest),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .acc_req(acc_req), .acc_write(acc_write),
    .acc_node(acc_node), .acc_reg(acc_reg), .acc_wdata(acc_wdata), .acc_done(acc_done),
    .acc_ok(acc_ok), .acc_rdata(acc_rdata));
  cfg_bank_model #(.NREG(NREG)) bank (.mclk(mclk), .srst(srst), .acc_req(acc_req),
    .acc_write(acc_write), .acc_node(acc_node), .acc_reg(acc_reg), .acc_wdata(acc_wdata),
    .acc_done(acc_done), .acc_ok(acc_ok), .acc_rdata(acc_rdata));
  always #20 mclk = ~mclk;
  task automatic chk(input string what, input logic [32:0] seen, input logic [32:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  function automatic int bank_of(input logic [31:0] dest);
    return (dest[15:0] == DEST_TILE) ? 0 : (dest[15:0] == DEST_NODE) ? 1 : 2;
  endfunction
  // Status identifier as a requester forms it; not a configuration register number
  function automatic logic [15:0] status_id(input logic [7:0] regn);
    return (16'(regn) << 8) | 16'h_000B;
  endfunction
  task automatic put(input logic c, input logic [7:0] d);
    logic r;
    rx_tok <= '{ctrl: c, data: d};
    rx_valid <= 1'b1;
    do begin
      @(negedge mclk) r = rx_ready;
      @(posedge mclk);
    end while (r !== 1'b1);
  endtask
  task automatic push(input logic [23:0] resp, input logic c, input logic [7:0] d);
    exp_q.push_back({resp, c, d});
  endtask
  // Form 0 normal, 1 extra byte, 2 end after register, 3 end inside reply field
  task automatic send(input bit wr, input logic [31:0] dest, input logic [23:0] resp,
                      input logic [15:0] rn, input logic [31:0] wd, input int form);
    int bk;
    bit good;
    bk = bank_of(dest);
    rx_dest <= dest;
    put(1'b1, wr ? TOK_WRITE : TOK_READ);
    for (int b = 2; b >= (form == 3 ? 1 : 0); b--) put(1'b0, resp[8*b+:8]);
    if (form != 3) begin
      for (int b = 1; b >= 0; b--) put(1'b0, rn[8*b+:8]);
      if (wr && form != 2) for (int b = 3; b >= 0; b--) put(1'b0, wd[8*b+:8]);
      if (form == 1) put(1'b0, 8'h_5A);
    end
    put(1'b1, TOK_END);
    if (form == 3) return;
    good = (bk < 2 && rn < NREG && form == 0);
    if (good && wr) shadow[bk][rn] = wd;
    if (wr && resp[7:0] == NO_REPLY_BYTE) return;
    push(resp, 1'b1, good ? TOK_ACK : TOK_NACK);
    if (good && !wr) for (int b = 3; b >= 0; b--) push(resp, 1'b0, shadow[bk][rn][8*b+:8]);
    push(resp, 1'b1, TOK_END);
  endtask
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    // Long stalls every 256 cycles back the input FIFO up
    tx_ready <= (cyc[7:6] != 2'h_3) && ($urandom % 4 != 0);
    if (!srst && rx_valid && rx_ready === 1'b0) refused <= refused + 1;
    if (!srst && tx_valid === 1'b1 && tx_ready) begin
      if (exp_q.size() == 0) chk("unexpected reply", {tx_dest, tx_tok}, 33'h_0);
      else chk("reply token", {tx_dest, tx_tok}, exp_q.pop_front());
    end
  end
  initial begin
    #(40 * 40000);
    error_cnt++;
    wrap_up();
  end
  initial begin
    logic [23:0] resp;
    mclk = 0;
    srst = 1;
    rx_valid = 0;
    rx_tok = '0;
    rx_dest = '0;
    foreach (shadow[b, r]) shadow[b][r] = 32'h_0000_0000;
    void'($urandom(98691));
    repeat (2) @(posedge mclk);
    chk("rx_ready in reset", 33'(rx_ready), 33'h_0);
    chk("tx_valid in reset", 33'(tx_valid), 33'h_0);
    srst <= 1'b0;
    repeat (2) @(posedge mclk);
    send(1, {16'h_0001, DEST_TILE}, 24'h_12_3456, 16'h_0003, 32'h_DEAD_BEEF, 0);
    send(0, {16'h_0001, DEST_TILE}, 24'h_12_3457, 16'h_0003, 0, 0);
    send(1, {16'h_0002, DEST_NODE}, 24'h_0A_0BFF, 16'h_000F, 32'h_0102_0304, 0);
    send(0, {16'h_0002, DEST_NODE}, 24'h_0A_0B00, 16'h_000F, 0, 0);
    send(0, {16'h_0002, DEST_TILE}, 24'h_0A_0B01, 16'h_000F, 0, 0);
    send(0, 32'h_0001_1234, 24'h_55_6677, 16'h_0001, 0, 0);
    send(1, {16'h_0001, DEST_TILE}, 24'h_55_6678, 16'h_0100, 32'h_1, 0);
    send(1, {16'h_0001, DEST_TILE}, 24'h_55_66FF, 16'h_0010, 32'h_1, 0);
    send(1, {16'h_0001, DEST_NODE}, 24'h_55_6679, 16'h_0002, 32'h_2, 1);
    send(1, {16'h_0001, DEST_NODE}, 24'h_55_667A, 16'h_0002, 32'h_3, 2);
    send(0, {16'h_0001, DEST_NODE}, 24'h_55_667B, 16'h_0002, 0, 3);
    send(1, {16'h_0001, DEST_TILE}, 24'h_55_667C, status_id(8'h_02), 32'h_4, 0);
    for (int i = 0; i < 80; i++) begin
      resp = 24'($urandom);
      if ($urandom % 5 == 0) resp[7:0] = NO_REPLY_BYTE;
      send(1'($urandom % 2), {16'($urandom), ($urandom % 2) ? DEST_NODE : DEST_TILE}, resp,
           16'($urandom % 20), $urandom, 0);
    end
    rx_valid <= 1'b0;
    for (int i = 0; i < 3000 && exp_q.size() != 0; i++) @(posedge mclk);
    chk("replies outstanding", 33'(exp_q.size()), 33'h_0);
    chk("input refused once", 33'(refused != 0), 33'h_1);
    wrap_up();
  end
endmodule
